// ### src/wd_map.svh
// register indices, field positions, keys, reset values and cycle counts
// of the supervision timer; included by the package-using design file
`ifndef WD_MAP_SVH
`define WD_MAP_SVH
// register indices; the byte address on the bus is four times the index
`define WD_IDX_CS_A 16'h3030
`define WD_IDX_CS_B 16'h3031
`define WD_IDX_CNT_H 16'h3032
`define WD_IDX_CNT_L 16'h3033
`define WD_IDX_EXP_H 16'h3034
`define WD_IDX_EXP_L 16'h3035
`define WD_IDX_WIN_H 16'h3036
`define WD_IDX_WIN_L 16'h3037
// bit positions in the two control/status bytes
`define WD_CSA_EN 7
`define WD_CSA_INT 6
`define WD_CSA_UPD 5
`define WD_CSB_WIN 7
`define WD_CSB_FLG 6
`define WD_CSB_DIVIDE_BY_256_ENABLE 4
// counter clock selection codes
`define WD_CLK_BUS 2'h0
`define WD_CLK_LPO 2'h1
`define WD_CLK_OSC 2'h2
`define WD_CLK_EXT 2'h3
// refresh and unlock words
`define WD_KEY_REF1 16'hA602
`define WD_KEY_REF2 16'hB480
`define WD_KEY_UNL1 16'hC520
`define WD_KEY_UNL2 16'hD928
// cycle counts in bus clocks; the prescaler last value counts selected reference ticks
`define WD_SEQ_LIMIT 5'h10
`define WD_CFG_LIMIT 8'h80
`define WD_IRQ_LAST 8'h7F
`define WD_PRE_LAST 8'hFF
// reset configuration
`define WD_RST_EN 1'h1
`define WD_RST_CLK 2'h1
`define WD_RST_EXPIRY 16'h0004
`define WD_RST_EARLY 16'h0000
`endif

// ### src/wd_pkg.sv
// types shared by the supervision timer
// assumes nothing of its surroundings
package wd_pkg;
   // one complete timer configuration
   typedef struct packed {
      logic en;
      logic irq_en;
      logic update;
      logic win_en;
      logic divide_by_256_enable;
      logic [1:0] clk_sel;
      logic [15:0] expiry;
      logic [15:0] early;
   } cfg_t;
   // refresh / unlock word sequence
   typedef enum logic [2:0] {
      SQ_IDLE = 3'h1,
      SQ_REF = 3'h2,
      SQ_UNL = 3'h4
   } seq_t;
   // reset-triggering event handling
   typedef enum logic [3:0] {
      EV_LIVE = 4'h1,
      EV_AWAIT = 4'h2,
      EV_DELAY = 4'h4,
      EV_FIRED = 4'h8
   } ev_t;
endpackage

// ### src/supervision_timer.sv
// windowed supervision timer with an APB register slave
// assumes an APB3 master on pclk and reference clock pins asynchronous to it
`timescale 1ns/10ps
`include "wd_map.svh"

// Notes on behaviour
// - write-once bit 7 enables early refresh check
// - pending flag sets on event, write-one clears
// - reserved bits 5, 3, 2 read zero
// - write-once bit 4 divides reference by 256
// - write-once two-bit counter clock select
// - counter readable anytime as two bytes
// - completed refresh clears the counter
// - refresh words within 16 clocks else reset
// - other counter writes force a reset
// - unlock allowed only with update permit
// - counter equal to expiry forces reset
// - refresh before window value forces reset
// - initial configuration only within 128 clocks
// - unlock words within 16 clocks, after configuration
// - rewrite within 128 clocks after unlock
// - interrupt first, reset 128 clocks after fetch
// - new configuration applies once all written
module supervision_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_power_1khz_osc,
   input wire logic internal_32khz_osc,
   input wire logic ext_clk_in,
   input wire logic vector_fetch,
   output logic irq,
   output logic sys_reset_req
);
   import wd_pkg::*;

   // byte address of a register index
   function automatic logic [15:0] addr_of(input logic [15:0] idx);
      addr_of = {idx[13:0], 2'h0};
   endfunction

   // configuration reset value
   function automatic cfg_t cfg_default();
      cfg_t c;
      c = '0;
      c.en = `WD_RST_EN;
      c.clk_sel = `WD_RST_CLK;
      c.expiry = `WD_RST_EXPIRY;
      c.early = `WD_RST_EARLY;
      cfg_default = c;
   endfunction

   logic wr_en;
   logic rd_setup;
   logic hit;
   logic wr_csa, wr_csb, wr_cnt_h, wr_cnt_l, wr_exp_h, wr_exp_l, wr_win_h, wr_win_l;
   logic [7:0] wbyte;
   cfg_t sh_q;
   cfg_t act_q;
   logic [5:0] wr_q;
   logic cfg_open_q;
   logic reconf_q;
   logic [7:0] cfg_cnt_q;
   logic cfg_full;
   logic ev_cfg_to;
   logic [2:0] sync1_q, sync2_q, sync3_q;
   logic [2:0] lvl_q;
   logic [2:0] lvl_d;
   logic [2:0] rise;
   logic src_tick;
   logic [7:0] pre_q;
   logic tick;
   logic [15:0] cnt_q;
   seq_t seq_q;
   seq_t seq_d;
   logic [4:0] seq_cnt_q;
   logic [7:0] hi_q;
   logic hi_valid_q;
   logic [15:0] word;
   logic ev_illegal;
   logic ev_early;
   logic ev_seq_to;
   logic ev_timeout;
   logic refresh_done;
   logic unlock_done;
   logic ev_any;
   ev_t ev_q;
   logic [7:0] dly_q;
   logic flag_q;
   logic flag_clr;
   logic [7:0] rd_byte;

   // apb decode: zero wait states, error on unmapped address
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign wbyte = pwdata[7:0];
   assign wr_csa = wr_en & (paddr == addr_of(`WD_IDX_CS_A));
   assign wr_csb = wr_en & (paddr == addr_of(`WD_IDX_CS_B));
   assign wr_cnt_h = wr_en & (paddr == addr_of(`WD_IDX_CNT_H));
   assign wr_cnt_l = wr_en & (paddr == addr_of(`WD_IDX_CNT_L));
   assign wr_exp_h = wr_en & (paddr == addr_of(`WD_IDX_EXP_H));
   assign wr_exp_l = wr_en & (paddr == addr_of(`WD_IDX_EXP_L));
   assign wr_win_h = wr_en & (paddr == addr_of(`WD_IDX_WIN_H));
   assign wr_win_l = wr_en & (paddr == addr_of(`WD_IDX_WIN_L));

   // read mux and address hit
   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      unique case (paddr)
         addr_of(`WD_IDX_CS_A): begin
            rd_byte[`WD_CSA_EN] = sh_q.en;
            rd_byte[`WD_CSA_INT] = sh_q.irq_en;
            rd_byte[`WD_CSA_UPD] = sh_q.update;
         end
         addr_of(`WD_IDX_CS_B): begin
            rd_byte[`WD_CSB_WIN] = sh_q.win_en;
            rd_byte[`WD_CSB_FLG] = flag_q;
            rd_byte[`WD_CSB_DIVIDE_BY_256_ENABLE] = sh_q.divide_by_256_enable;
            rd_byte[1:0] = sh_q.clk_sel;
         end
         addr_of(`WD_IDX_CNT_H): rd_byte = cnt_q[15:8];
         addr_of(`WD_IDX_CNT_L): rd_byte = cnt_q[7:0];
         addr_of(`WD_IDX_EXP_H): rd_byte = sh_q.expiry[15:8];
         addr_of(`WD_IDX_EXP_L): rd_byte = sh_q.expiry[7:0];
         addr_of(`WD_IDX_WIN_H): rd_byte = sh_q.early[15:8];
         addr_of(`WD_IDX_WIN_L): rd_byte = sh_q.early[7:0];
         default: hit = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~hit;

   // read data is captured in the setup cycle, so it stands in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= {24'h00_0000, rd_byte};
      end
   end

   // configuration complete once every needed register was written
   assign cfg_full = (&wr_q[3:0]) & (~sh_q.win_en | (&wr_q[5:4]));
   assign ev_cfg_to = cfg_open_q & reconf_q & ~cfg_full & (cfg_cnt_q == `WD_CFG_LIMIT);

   // write-once shadow, configuration interval and the active copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_q <= cfg_default();
         act_q <= cfg_default();
         wr_q <= 6'h00;
         cfg_open_q <= 1'b1;
         reconf_q <= 1'b0;
         cfg_cnt_q <= 8'h00;
      end else begin
         if (cfg_open_q) begin
            // writes only land inside the interval, once each
            if (wr_csa && !wr_q[0]) begin
               sh_q.en <= wbyte[`WD_CSA_EN];
               sh_q.irq_en <= wbyte[`WD_CSA_INT];
               sh_q.update <= wbyte[`WD_CSA_UPD];
               wr_q[0] <= 1'b1;
            end
            if (wr_csb && !wr_q[1]) begin
               sh_q.win_en <= wbyte[`WD_CSB_WIN];
               sh_q.divide_by_256_enable <= wbyte[`WD_CSB_DIVIDE_BY_256_ENABLE];
               sh_q.clk_sel <= wbyte[1:0];
               wr_q[1] <= 1'b1;
            end
            if (wr_exp_h && !wr_q[2]) begin
               sh_q.expiry[15:8] <= wbyte;
               wr_q[2] <= 1'b1;
            end
            if (wr_exp_l && !wr_q[3]) begin
               sh_q.expiry[7:0] <= wbyte;
               wr_q[3] <= 1'b1;
            end
            if (wr_win_h && !wr_q[4]) begin
               sh_q.early[15:8] <= wbyte;
               wr_q[4] <= 1'b1;
            end
            if (wr_win_l && !wr_q[5]) begin
               sh_q.early[7:0] <= wbyte;
               wr_q[5] <= 1'b1;
            end
            if (cfg_full) begin
               act_q <= sh_q;
               cfg_open_q <= 1'b0;
               reconf_q <= 1'b0;
            end else if (cfg_cnt_q == `WD_CFG_LIMIT) begin
               cfg_open_q <= 1'b0;
            end else begin
               cfg_cnt_q <= cfg_cnt_q + 8'h01;
            end
         end else if (unlock_done) begin
            // reopen for one more write of each register
            cfg_open_q <= 1'b1;
            reconf_q <= 1'b1;
            cfg_cnt_q <= 8'h00;
            wr_q <= 6'h00;
         end
      end
   end

   // three-stage synchronisers on the reference clock pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
         lvl_q <= 3'h0;
      end else begin
         sync1_q <= {ext_clk_in, internal_32khz_osc, low_power_1khz_osc};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         lvl_q <= lvl_d;
      end
   end

   // a level change counts only when stages two and three agree
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         lvl_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : lvl_q[i];
      end
      rise = lvl_d & ~lvl_q;
   end

   // reference clock selection
   always_comb begin
      unique case (act_q.clk_sel)
         `WD_CLK_BUS: src_tick = 1'b1;
         `WD_CLK_LPO: src_tick = rise[0];
         `WD_CLK_OSC: src_tick = rise[1];
         `WD_CLK_EXT: src_tick = rise[2];
      endcase
   end

   assign tick = src_tick & (~act_q.divide_by_256_enable | (pre_q == `WD_PRE_LAST));

   // fixed divide by 256 on the selected reference
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 8'h00;
      end else if (src_tick) begin
         pre_q <= pre_q + 8'h01;
      end
   end

   // free-running counter, cleared by a completed refresh
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
      end else if (refresh_done) begin
         cnt_q <= 16'h0000;
      end else if (act_q.en && tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   assign ev_timeout = act_q.en & (cnt_q == act_q.expiry);
   assign word = {hi_q, wbyte};

   // decode of words written to the counter pair
   always_comb begin
      seq_d = seq_q;
      ev_illegal = 1'b0;
      ev_early = 1'b0;
      refresh_done = 1'b0;
      unlock_done = 1'b0;
      ev_seq_to = (seq_q != SQ_IDLE) & (seq_cnt_q == `WD_SEQ_LIMIT) & ~wr_cnt_l;
      if (wr_cnt_h && hi_valid_q) begin
         ev_illegal = 1'b1;
      end
      if (wr_cnt_l && !hi_valid_q) begin
         ev_illegal = 1'b1;
      end else if (wr_cnt_l) begin
         seq_d = SQ_IDLE;
         unique case (seq_q)
            SQ_IDLE: begin
               if (word == `WD_KEY_REF1) begin
                  seq_d = SQ_REF;
                  ev_early = act_q.win_en & (cnt_q < act_q.early);
               end else if (word == `WD_KEY_UNL1 && act_q.update && !cfg_open_q) begin
                  seq_d = SQ_UNL;
               end else begin
                  ev_illegal = 1'b1;
               end
            end
            SQ_REF: begin
               refresh_done = (word == `WD_KEY_REF2);
               ev_illegal = (word != `WD_KEY_REF2);
            end
            SQ_UNL: begin
               unlock_done = (word == `WD_KEY_UNL2);
               ev_illegal = (word != `WD_KEY_UNL2);
            end
         endcase
      end else if (ev_seq_to) begin
         seq_d = SQ_IDLE;
      end
   end

   // sequence state, gap counter and pending high byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_q <= SQ_IDLE;
         seq_cnt_q <= 5'h00;
         hi_q <= 8'h00;
         hi_valid_q <= 1'b0;
      end else begin
         seq_q <= seq_d;
         if (seq_d != seq_q || seq_q == SQ_IDLE) begin
            seq_cnt_q <= 5'h00;
         end else begin
            seq_cnt_q <= seq_cnt_q + 5'h01;
         end
         if (wr_cnt_h) begin
            hi_q <= wbyte;
            hi_valid_q <= 1'b1;
         end else if (wr_cnt_l) begin
            hi_valid_q <= 1'b0;
         end
      end
   end

   assign ev_any = ev_timeout | ev_illegal | ev_early | ev_seq_to | ev_cfg_to;
   assign flag_clr = wr_csb & wbyte[`WD_CSB_FLG];

   // event handling: interrupt first when enabled, then the forced reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_q <= EV_LIVE;
         dly_q <= 8'h00;
      end else begin
         unique case (ev_q)
            EV_LIVE: begin
               if (ev_any) begin
                  ev_q <= act_q.irq_en ? EV_AWAIT : EV_FIRED;
               end
            end
            EV_AWAIT: begin
               if (vector_fetch) begin
                  ev_q <= EV_DELAY;
                  dly_q <= 8'h00;
               end
            end
            EV_DELAY: begin
               if (dly_q == `WD_IRQ_LAST) begin
                  ev_q <= EV_FIRED;
               end else begin
                  dly_q <= dly_q + 8'h01;
               end
            end
            EV_FIRED: ev_q <= EV_FIRED;
         endcase
      end
   end

   // pending flag: a new event wins over the write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (ev_any && act_q.irq_en && ev_q == EV_LIVE) begin
         flag_q <= 1'b1;
      end else if (flag_clr) begin
         flag_q <= 1'b0;
      end
   end

   assign irq = flag_q;
   assign sys_reset_req = (ev_q == EV_FIRED);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_taken;
      ##1 (ev_q != EV_LIVE);
   endsequence
   sequence s_fired;
      ##1 (ev_q == EV_FIRED);
   endsequence

   AST_FLAG_CLEAR: assert property (flag_clr && !ev_any |=> !flag_q)
      else $error("pending flag not cleared");
   AST_RESV_ZERO: assert property (rd_setup && paddr == addr_of(`WD_IDX_CS_B) |=> prdata[5:2] == {1'b0, prdata[4], 2'h0})
      else $error("reserved bits not zero");
   AST_REFRESH: assert property (refresh_done |=> cnt_q == 16'h0000)
      else $error("refresh did not clear counter");
   // helper: cycles spent waiting for the second refresh word, apart from the sequence counter
   logic [4:0] gap_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_q <= 5'h00;
      end else if (seq_q == SQ_REF) begin
         gap_q <= gap_q + 5'h01;
      end else begin
         gap_q <= 5'h00;
      end
   end

   AST_SEQ_GAP: assert property (seq_q == SQ_REF && gap_q == `WD_SEQ_LIMIT && !wr_cnt_l |-> s_taken)
      else $error("refresh gap not punished");
   AST_ILLEGAL: assert property (ev_illegal |-> s_taken)
      else $error("illegal write ignored");
   AST_EXPIRY: assert property (act_q.en && cnt_q == act_q.expiry |-> s_taken)
      else $error("expiry ignored");
   AST_EARLY: assert property (wr_cnt_l && seq_q == SQ_IDLE && word == `WD_KEY_REF1 && act_q.win_en
      && cnt_q < act_q.early |-> s_taken)
      else $error("early refresh ignored");
   AST_NO_IRQ: assert property (ev_q == EV_LIVE && ev_any && !act_q.irq_en |-> s_fired)
      else $error("reset not immediate");
   AST_IRQ_DELAY: assert property (ev_q == EV_AWAIT && vector_fetch |=> (ev_q == EV_DELAY) [*8] ##120 s_fired)
      else $error("delayed reset timing wrong");
   AST_ONCE: assert property (wr_exp_h && wr_q[2] |=> $stable(sh_q.expiry[15:8]))
      else $error("write-once register changed");
   AST_STEP: assert property (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + 16'h0001 || cnt_q == 16'h0000)
      else $error("counter jumped");
   AST_WINDOW: assert property (cfg_cnt_q <= `WD_CFG_LIMIT)
      else $error("configuration interval overrun");
endmodule

// ### verification/tb_supervision_timer.sv
// self-checking bench for the supervision timer, driving its APB slave directly
// assumes src/wd_map.svh on the include path; the three reference clock pins stay low except while the reference pin test enables them
`timescale 1ns/10ps
`include "wd_map.svh"

module tb_supervision_timer;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic vector_fetch;
   logic [15:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic err_q;
   logic irq;
   logic sys_reset_req;
   logic [7:0] v;
   int num_errors;
   int tests_run;
   int cycles = 0;
   logic [2:0] ref_div = 3'h0;
   logic [2:0] ref_en;

   supervision_timer supervision_timer_i (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .low_power_1khz_osc(ref_div[2] & ref_en[0]),
      .internal_32khz_osc(ref_div[2] & ref_en[1]),
      .ext_clk_in(ref_div[2] & ref_en[2]),
      .vector_fetch(vector_fetch),
      .irq(irq),
      .sys_reset_req(sys_reset_req)
   );

   // 10 MHz bus clock
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   // reference pins: one period every 8 bus clocks, each pin gated by its enable
   always @(posedge pclk) begin
      ref_div <= ref_div + 3'h1;
   end

   // hang guard: whole run is a few thousand cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         $display("FAIL at %0t: timeout, got %h expected %h", $time, cycles, 0);
         close_out();
      end
   end

   // verdict and end of run
   task close_out;
      $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task bitchk(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // one APB transfer: setup, access held until pready is sampled high
   task xfer(input logic wr, input logic [15:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx[13:0], 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [15:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask

   task rdchk(input logic [15:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask

   // counter word as high byte then low byte
   task word(input logic [15:0] w);
      wr(`WD_IDX_CNT_H, w[15:8]);
      wr(`WD_IDX_CNT_L, w[7:0]);
   endtask

   task cfg(input logic [7:0] a, input logic [7:0] b, input logic [15:0] e);
      wr(`WD_IDX_CS_A, a);
      wr(`WD_IDX_CS_B, b);
      wr(`WD_IDX_EXP_H, e[15:8]);
      wr(`WD_IDX_EXP_L, e[7:0]);
   endtask

   task do_reset;
      if (presetn) @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // let n edges pass, then sample outputs away from the edge
   task settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask

   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      vector_fetch = 1'b0;
      num_errors = 0;
      tests_run = 0;
      ref_en = 3'h0;
      do_reset();
      rdchk(`WD_IDX_CS_B, 32'h0000_0001);
      rdchk(`WD_IDX_EXP_L, 32'h0000_0004);
      rdchk(16'h3040, 32'h0000_0000);
      bitchk(err_q, 1'b1);
      $display("test reset_values done");
      // windowed configuration, reserved bits written as ones
      cfg(8'hA0, 8'hEC, 16'h0100);
      wr(`WD_IDX_WIN_H, 8'h00);
      wr(`WD_IDX_WIN_L, 8'h40);
      wr(`WD_IDX_EXP_L, 8'h55);
      rdchk(`WD_IDX_CS_B, 32'h0000_0080);
      rdchk(`WD_IDX_EXP_L, 32'h0000_0000);
      settle(100);
      rdchk(`WD_IDX_CNT_H, 32'h0000_0000);
      xfer(1'b0, `WD_IDX_CNT_L, 8'h00);
      bitchk(rd >= 32'h0000_0040 && rd < 32'h0000_00C0, 1'b1);
      word(`WD_KEY_REF1);
      word(`WD_KEY_REF2);
      rdchk(`WD_IDX_CNT_H, 32'h0000_0000);
      xfer(1'b0, `WD_IDX_CNT_L, 8'h00);
      bitchk(rd < 32'h0000_0010, 1'b1);
      settle(1);
      bitchk(sys_reset_req, 1'b0);
      $display("test refresh done");
      // unlock, reconfigure with interrupt, then an illegal counter write
      word(`WD_KEY_UNL1);
      word(`WD_KEY_UNL2);
      cfg(8'hE0, 8'h00, 16'h0800);
      rdchk(`WD_IDX_CS_A, 32'h0000_00E0);
      settle(150);
      bitchk(sys_reset_req, 1'b0);
      wr(`WD_IDX_CNT_L, 8'h00);
      settle(3);
      bitchk(irq, 1'b1);
      bitchk(sys_reset_req, 1'b0);
      rdchk(`WD_IDX_CS_B, 32'h0000_0040);
      wr(`WD_IDX_CS_B, 8'h40);
      settle(1);
      bitchk(irq, 1'b0);
      @(posedge pclk);
      vector_fetch <= 1'b1;
      @(posedge pclk);
      vector_fetch <= 1'b0;
      settle(120);
      bitchk(sys_reset_req, 1'b0);
      settle(15);
      bitchk(sys_reset_req, 1'b1);
      $display("test interrupt_delay done");
      // expiry on the bus clock without interrupt
      do_reset();
      cfg(8'h80, 8'h00, 16'h0020);
      settle(20);
      bitchk(sys_reset_req, 1'b0);
      settle(30);
      bitchk(sys_reset_req, 1'b1);
      $display("test expiry done");
      // refresh started before the window value
      do_reset();
      cfg(8'h80, 8'h80, 16'h0200);
      wr(`WD_IDX_WIN_H, 8'h00);
      wr(`WD_IDX_WIN_L, 8'h80);
      word(`WD_KEY_REF1);
      settle(4);
      bitchk(sys_reset_req, 1'b1);
      $display("test early_refresh done");
      // second refresh word never arrives
      do_reset();
      cfg(8'h80, 8'h00, 16'h0400);
      word(`WD_KEY_REF1);
      settle(8);
      bitchk(sys_reset_req, 1'b0);
      settle(16);
      bitchk(sys_reset_req, 1'b1);
      $display("test refresh_gap done");
      // unlock not followed by a rewrite
      do_reset();
      cfg(8'hA0, 8'h00, 16'h0400);
      word(`WD_KEY_UNL1);
      word(`WD_KEY_UNL2);
      settle(100);
      bitchk(sys_reset_req, 1'b0);
      settle(40);
      bitchk(sys_reset_req, 1'b1);
      $display("test unlock_timeout done");
      // every clock select code, prescaler on odd codes
      for (int i = 0; i < 4; i++) begin
         v = {3'b000, i[0], 2'b00, i[1:0]};
         do_reset();
         wr(`WD_IDX_CS_B, v);
         rdchk(`WD_IDX_CS_B, {24'h00_0000, v});
      end
      $display("test clock_codes done");
      // counter fed from each reference pin, pins start only once configured
      for (int k = 0; k < 3; k++) begin
         do_reset();
         cfg(8'h80, k[7:0] + 8'h01, 16'h0100);
         ref_en <= 3'h1 << k[1:0];
         settle(80);
         xfer(1'b0, `WD_IDX_CNT_L, 8'h00);
         bitchk(rd >= 32'h0000_0008 && rd <= 32'h0000_000C, 1'b1);
         ref_en <= 3'h0;
      end
      // bus clock divided by 256 ticks the counter twice in about 600 clocks
      do_reset();
      cfg(8'h80, 8'h10, 16'h0400);
      settle(600);
      xfer(1'b0, `WD_IDX_CNT_L, 8'h00);
      bitchk(rd >= 32'h0000_0001 && rd <= 32'h0000_0003, 1'b1);
      $display("test reference_clocks done");
      // configuration after the open interval is ignored
      do_reset();
      settle(140);
      wr(`WD_IDX_EXP_L, 8'h33);
      rdchk(`WD_IDX_EXP_L, 32'h0000_0004);
      $display("test late_config done");
      close_out();
   end
endmodule
